// file: src/its_target.sv
// Two-wire bus target giving a controller word access to internal registers
// Overview of operation
// - Target only; never drives the clock line.
// - Fast mode to 400 kHz, high speed 2.94 MHz.
// - Words travel high byte first, then low.
// - Address is 100, high pin code, low code.
// - Select pins resampled at every start condition.
// - Ack address, pointer, two data bytes; store word.
// - Pointer-only write is accepted without data.
// - Read returns pointed register, high then low.
// - Pointer is kept across transactions.
// - No error-check byte, no clock stretching.
// - High-speed code unacked; filters switch to high speed.
// - High speed persists over restarts; stop ends it.
// - Pending alert: ack response address, send own address.
// - Losing arbitration keeps alert asserted, no ack.
// - Held alert released by diagnostic register read.
// - Alert active low, inverted by polarity select.
`timescale 1ns/10ps
module its_target (
  input wire logic mclk,                          // System clock, 100 MHz
  input wire logic rst,                           // Synchronous reset, active high
  input wire logic scl_i,                         // Bus clock line level
  input wire logic sda_i,                         // Bus data line level
  output logic sda_o,                             // Data line drive value, always low
  output logic sda_oe,                            // Data line pulled low when high
  input wire logic [1:0] addr_select_low_pin,     // Low select pin code
  input wire logic [1:0] addr_select_high_pin,    // High select pin code
  output logic [7:0] rd_ptr,                      // Register pointer
  input wire logic [15:0] rd_data,                // Contents of pointed register
  output its_pkg::its_wr_type wr,                 // One-cycle register write
  input wire logic alert_cond,                    // Diagnostic condition active
  input wire logic alert_hold_enable,             // Keep alert after condition clears
  input wire logic alert_polarity_select,         // Alert active high when set
  output logic alert_o,                           // Alert drive value, always low
  output logic alert_oe,                          // Alert line pulled low when high
  output logic hs_mode                            // High-speed filtering active
);
  import its_pkg::*;

  // ------------------------------------------------------------------
  // Input synchronisers and spike filters
  // ------------------------------------------------------------------
  logic [1:0] s1_r, s2_r;
  logic [3:0] pin1_r, pin2_r;
  logic line_r [2];
  logic [2:0] cnt_r [2];
  logic [1:0] prev_r;
  logic hs_mode_r;
  wire [2:0] filt_cyc = hs_mode_r ? HS_FILT_CYC : FS_FILT_CYC;

  always_ff @(posedge mclk) begin
    s1_r <= {sda_i, scl_i};
    s2_r <= s1_r;
    pin1_r <= {addr_select_high_pin, addr_select_low_pin};
    pin2_r <= pin1_r;
    prev_r <= {line_r[1], line_r[0]};
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_filt
      always_ff @(posedge mclk) begin
        if (rst) begin
          line_r[g] <= 1'b1;
          cnt_r[g] <= 3'h0;
        end else if (s2_r[g] == line_r[g]) begin
          cnt_r[g] <= 3'h0;
        end else if (cnt_r[g] == 3'(filt_cyc - 3'h1)) begin
          line_r[g] <= s2_r[g];
          cnt_r[g] <= 3'h0;
        end else begin
          cnt_r[g] <= 3'(cnt_r[g] + 3'h1);
        end
      end
    end
  endgenerate

  wire scl_f = line_r[0];
  wire sda_f = line_r[1];
  wire scl_rise = scl_f & ~prev_r[0];
  wire scl_fall = ~scl_f & prev_r[0];
  wire start_ev = scl_f & prev_r[0] & prev_r[1] & ~sda_f;
  wire stop_ev = scl_f & prev_r[0] & ~prev_r[1] & sda_f;

  // ------------------------------------------------------------------
  // Byte sequencing
  // ------------------------------------------------------------------
  its_state_type st_r;
  logic [3:0] bitcnt_r;
  logic [2:0] idx_r;
  logic [7:0] sh_r, ptr_r, hi_r, tx_sh_r, tx_lo_r;
  logic [6:0] own_r;
  logic rd_r, ara_r, ack_r, cur_r, more_r, second_r, sda_oe_r, zero_r;
  logic won_r, lost_r, diag_rd_r, pend_r, cond_q_r, alert_oe_r;
  its_wr_type wr_r;

  wire [7:0] rx_byte = {sh_r[6:0], sda_f};
  wire addr_hit = rx_byte[7:1] == own_r;
  wire ara_hit = (rx_byte[7:1] == ARA_ADDR) & rx_byte[0] & pend_r;
  wire hs_hit = rx_byte[7:3] == HS_CODE_TOP;
  // Address byte acked only on a match; data acked up to the low byte
  wire rx_ack = (idx_r == 3'h0) ? (addr_hit | ara_hit) : (idx_r <= LAST_DATA_IDX);
  wire [7:0] tx_first = ara_r ? {own_r, 1'b0} : rd_data[15:8];

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= ST_IDLE;
      bitcnt_r <= 4'h0;
      idx_r <= 3'h0;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      hi_r <= 8'h00;
      tx_sh_r <= 8'h00;
      tx_lo_r <= 8'h00;
      own_r <= 7'h00;
      rd_r <= 1'b0;
      ara_r <= 1'b0;
      ack_r <= 1'b0;
      cur_r <= 1'b1;
      more_r <= 1'b0;
      second_r <= 1'b0;
      sda_oe_r <= 1'b0;
      hs_mode_r <= 1'b0;
      wr_r <= '0;
      won_r <= 1'b0;
      lost_r <= 1'b0;
      diag_rd_r <= 1'b0;
      zero_r <= 1'b0;
    end else begin
      wr_r.en <= 1'b0;
      won_r <= 1'b0;
      lost_r <= 1'b0;
      diag_rd_r <= 1'b0;
      zero_r <= 1'b0;
      if (stop_ev) begin
        st_r <= ST_IDLE;
        sda_oe_r <= 1'b0;
        hs_mode_r <= 1'b0;
      end else if (start_ev) begin
        st_r <= ST_RX;
        bitcnt_r <= 4'h0;
        idx_r <= 3'h0;
        rd_r <= 1'b0;
        ara_r <= 1'b0;
        sda_oe_r <= 1'b0;
        own_r <= {ADDR_PREFIX, pin2_r};
      end else begin
        case (st_r)
          ST_RX: begin
            if (scl_rise) begin
              sh_r <= rx_byte;
              bitcnt_r <= 4'(bitcnt_r + 4'h1);
              if (bitcnt_r == BYTE_BITS - 4'h1) begin
                ack_r <= rx_ack;
                if (idx_r == 3'h0) begin
                  rd_r <= rx_byte[0];
                  ara_r <= ara_hit & ~addr_hit;
                  if (hs_hit) hs_mode_r <= 1'b1;
                end else if (idx_r == 3'h1) begin
                  ptr_r <= rx_byte;
                end else if (idx_r == 3'h2) begin
                  hi_r <= rx_byte;
                end else if (idx_r == LAST_DATA_IDX) begin
                  wr_r <= '{en: 1'b1, ptr: ptr_r, data: {hi_r, rx_byte}};
                end
              end
            end else if (scl_fall && bitcnt_r == BYTE_BITS) begin
              idx_r <= (idx_r == 3'h7) ? idx_r : 3'(idx_r + 3'h1);
              if (ack_r) begin
                sda_oe_r <= 1'b1;
                st_r <= ST_ACK;
              end else begin
                st_r <= ST_WAIT;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bitcnt_r <= 4'h0;
              if (rd_r) begin
                // Load happens at the ack fall so rd_data reflects the kept pointer
                cur_r <= tx_first[7];
                sda_oe_r <= ~tx_first[7];
                tx_sh_r <= {tx_first[6:0], 1'b0};
                tx_lo_r <= rd_data[7:0];
                second_r <= 1'b0;
                diag_rd_r <= ~ara_r & (ptr_r == DIAG_PTR);
                st_r <= ST_TX;
              end else begin
                sda_oe_r <= 1'b0;
                st_r <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              bitcnt_r <= 4'(bitcnt_r + 4'h1);
              if (ara_r && cur_r && !sda_f) begin
                lost_r <= 1'b1;
                sda_oe_r <= 1'b0;
                st_r <= ST_WAIT;
              end else if (ara_r && bitcnt_r == BYTE_BITS - 4'h1) begin
                won_r <= 1'b1;
              end
            end else if (scl_fall) begin
              if (bitcnt_r == BYTE_BITS) begin
                sda_oe_r <= 1'b0;
                st_r <= ST_TACK;
              end else begin
                cur_r <= tx_sh_r[7];
                sda_oe_r <= ~tx_sh_r[7];
                tx_sh_r <= {tx_sh_r[6:0], 1'b0};
              end
            end
          end
          ST_TACK: begin
            if (scl_rise) begin
              more_r <= ~sda_f & ~second_r & ~ara_r;
            end else if (scl_fall) begin
              if (more_r) begin
                cur_r <= tx_lo_r[7];
                sda_oe_r <= ~tx_lo_r[7];
                tx_sh_r <= {tx_lo_r[6:0], 1'b0};
                bitcnt_r <= 4'h0;
                second_r <= 1'b1;
                st_r <= ST_TX;
              end else begin
                st_r <= ST_WAIT;
              end
            end
          end
          ST_IDLE, ST_WAIT: begin
            sda_oe_r <= 1'b0;
          end
          default: begin
            st_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // Alert line
  // ------------------------------------------------------------------
  // A new condition edge wins over any release in the same cycle
  wire alert_set = alert_cond & ~cond_q_r;
  wire alert_clr = won_r | (diag_rd_r & alert_hold_enable);
  wire pend_nxt = alert_set | (pend_r & ~alert_clr & (alert_hold_enable | alert_cond));

  always_ff @(posedge mclk) begin
    if (rst) begin
      cond_q_r <= 1'b0;
      pend_r <= 1'b0;
      alert_oe_r <= 1'b0;
    end else begin
      cond_q_r <= alert_cond;
      pend_r <= pend_nxt;
      alert_oe_r <= pend_r ^ alert_polarity_select;
    end
  end

  assign sda_o = zero_r;
  assign sda_oe = sda_oe_r;
  assign rd_ptr = ptr_r;
  assign wr = wr_r;
  assign alert_o = zero_r;
  assign alert_oe = alert_oe_r;
  assign hs_mode = hs_mode_r;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_byte_end;
    st_r == ST_RX && scl_fall && bitcnt_r == BYTE_BITS;
  endsequence
  sequence s_hs_code;
    st_r == ST_RX && scl_rise && bitcnt_r == 4'h7 && idx_r == 3'h0 && hs_hit && !addr_hit;
  endsequence

  property p_drive_only_ack_tx;
    sda_oe_r |-> (st_r == ST_ACK || st_r == ST_TX);
  endproperty
  a_drive_only_ack_tx: assert property (p_drive_only_ack_tx) else $error("data line driven outside ack or send");
  property p_hs_no_ack;
    s_hs_code |=> !ack_r && hs_mode_r ##1 !sda_oe_r [*8];
  endproperty
  a_hs_no_ack: assert property (p_hs_no_ack) else $error("high-speed code was acknowledged");
  property p_stop_ends_hs;
    stop_ev |=> !hs_mode_r && !sda_oe_r && st_r == ST_IDLE;
  endproperty
  a_stop_ends_hs: assert property (p_stop_ends_hs) else $error("stop did not end high speed");
  property p_start_resets;
    (start_ev && !stop_ev) |=> st_r == ST_RX && bitcnt_r == 4'h0 && idx_r == 3'h0;
  endproperty
  a_start_resets: assert property (p_start_resets) else $error("start did not reset sequencing");
  property p_write_pulse;
    wr_r.en |-> wr_r.ptr == ptr_r ##1 !wr_r.en;
  endproperty
  a_write_pulse: assert property (p_write_pulse) else $error("write not a single pulse to pointer");
  property p_ptr_kept;
    !(st_r == ST_RX && idx_r == 3'h1 && scl_rise) |=> ptr_r == $past(ptr_r);
  endproperty
  a_ptr_kept: assert property (p_ptr_kept) else $error("pointer changed without a pointer byte");
  property p_alert_level;
    ##1 alert_oe_r == ($past(pend_r) ^ $past(alert_polarity_select));
  endproperty
  a_alert_level: assert property (p_alert_level) else $error("alert level disagrees with polarity");
  property p_lost_keeps_alert;
    lost_r |-> pend_r ##1 pend_r;
  endproperty
  a_lost_keeps_alert: assert property (p_lost_keeps_alert) else $error("alert dropped after lost arbitration");
  property p_nack_releases;
    s_byte_end ##0 !ack_r |=> !sda_oe_r [*3];
  endproperty
  a_nack_releases: assert property (p_nack_releases) else $error("unmatched byte acknowledged");
endmodule : its_target

// file: src/its_pkg.sv
// Shared constants and types for the two-wire register-access target
package its_pkg;
  // ------------------------------------------------------------------
  // Addressing
  // ------------------------------------------------------------------
  localparam logic [2:0] ADDR_PREFIX = 3'h4;     // Fixed upper address bits 100
  localparam logic [6:0] ARA_ADDR = 7'h0c;       // Alert response address 0001 100
  localparam logic [4:0] HS_CODE_TOP = 5'h01;    // High-speed code 00001XXX
  localparam logic [7:0] DIAG_PTR = 8'h0b;       // Pointer of the diagnostic flags register
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [2:0] LAST_DATA_IDX = 3'h3;   // Address, pointer, high, low
  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int FS_MAX_KHZ = 400;
  localparam int HS_MAX_KHZ = 2940;
  localparam int FS_SPIKE_NS = 50;
  localparam int HS_SPIKE_NS = 10;
  localparam int FS_FILT_INT = (FS_SPIKE_NS * CLK_MHZ) / 1000;
  localparam int HS_FILT_INT = (HS_SPIKE_NS * CLK_MHZ) / 1000;
  localparam logic [2:0] FS_FILT_CYC = 3'((FS_FILT_INT < 1) ? 1 : FS_FILT_INT);
  localparam logic [2:0] HS_FILT_CYC = 3'((HS_FILT_INT < 1) ? 1 : HS_FILT_INT);
  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX = 6'h02,
    ST_ACK = 6'h04,
    ST_TX = 6'h08,
    ST_TACK = 6'h10,
    ST_WAIT = 6'h20
  } its_state_type;

  typedef struct packed {
    logic en;
    logic [7:0] ptr;
    logic [15:0] data;
  } its_wr_type;
endpackage : its_pkg

// file: test/its_ctrl_model.sv
// Bus controller model that opens, clocks and closes two-wire transfers
`timescale 1ns/10ps
module its_ctrl_model (
  input wire logic mclk,      // Pacing clock
  input wire logic sda_line,  // Resolved data line level
  output logic scl_pull,      // Pulls clock line low when high
  output logic sda_pull       // Pulls data line low when high
);
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(negedge mclk);
  endtask : w
  // ----------
  // Bit timing
  // ----------
  // Link period is 16 mclk; data moves 80 ns after the fall, so the target has released first
  task automatic bit_x(input logic b, output logic s);
    w(8);
    sda_pull = ~b;
    w(2);
    scl_pull = 1'b0;
    w(3);
    s = sda_line;
    w(3);
    scl_pull = 1'b1;
  endtask : bit_x
  task automatic start();
    w(8);
    sda_pull = 1'b0;
    w(2);
    scl_pull = 1'b0;
    w(6);
    sda_pull = 1'b1;
    w(6);
    scl_pull = 1'b1;
  endtask : start
  // Ends a transfer only at a byte boundary
  task automatic stop();
    w(8);
    sda_pull = 1'b1;
    w(2);
    scl_pull = 1'b0;
    w(6);
    sda_pull = 1'b0;
    w(6);
  endtask : stop
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i], s);
    end
    bit_x(1'b1, s);
    ack = ~s;
  endtask : wbyte
  // Controller acks the high byte, acks or not the low byte
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(~ack, s);
  endtask : rbyte
endmodule : its_ctrl_model

// file: test/its_target_tb.sv
// Self-checking bench for the two-wire register-access target
`timescale 1ns/10ps
module its_target_tb;
  import its_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic rival = 1'b0;
  logic [1:0] pin_lo = 2'h0;
  logic [1:0] pin_hi = 2'h0;
  logic cond = 1'b0;
  logic hold = 1'b0;
  logic pol = 1'b0;
  logic scl_pull, sda_pull, sda_oe, alert_oe, hs_mode, a, sda_o, alert_o;
  logic [7:0] rd_ptr, d;
  logic [15:0] v;
  its_wr_type wr, wr_last;
  int fail_count = 0;
  int checks_done = 0;
  int wr_cnt = 0;
  // Open-drain lines: low when anyone pulls
  wire scl_i = ~scl_pull;
  wire sda_i = ~(sda_pull | sda_oe | rival);
  wire [15:0] rd_data = {rd_ptr, ~rd_ptr};
  wire [6:0] own = {ADDR_PREFIX, pin_hi, pin_lo};
  its_target u_dut (.mclk(mclk), .rst(rst), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .addr_select_low_pin(pin_lo), .addr_select_high_pin(pin_hi), .rd_ptr(rd_ptr), .rd_data(rd_data),
    .wr(wr), .alert_cond(cond), .alert_hold_enable(hold), .alert_polarity_select(pol), .alert_o(alert_o),
    .alert_oe(alert_oe), .hs_mode(hs_mode));
  its_ctrl_model u_ctrl (.mclk(mclk), .sda_line(sda_i), .scl_pull(scl_pull), .sda_pull(sda_pull));
  initial begin
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (wr.en === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      wr_last <= wr;
    end
  end
  // ----------
  // Checks and transfers
  // ----------
  task automatic chk_v(input logic [24:0] g, input logic [24:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk_v
  task automatic chk_b(input logic g, input logic e);
    chk_v({24'h0, g}, {24'h0, e});
  endtask : chk_b
  // Pointer write with n data bytes; the caller closes the transfer
  task automatic xfer_w(input logic [7:0] ptr, input int n, input logic [15:0] dv);
    u_ctrl.start();
    u_ctrl.wbyte({own, 1'b0}, a);
    chk_b(a, 1'b1);
    u_ctrl.wbyte(ptr, a);
    chk_b(a, 1'b1);
    if (n > 0) begin
      u_ctrl.wbyte(dv[15:8], a);
      chk_b(a, 1'b1);
    end
    if (n > 1) begin
      u_ctrl.wbyte(dv[7:0], a);
      chk_b(a, 1'b1);
    end
  endtask : xfer_w
  task automatic rd_w(output logic [15:0] r);
    u_ctrl.start();
    u_ctrl.wbyte({own, 1'b1}, a);
    chk_b(a, 1'b1);
    u_ctrl.rbyte(1'b1, r[15:8]);
    u_ctrl.rbyte(1'b0, r[7:0]);
    u_ctrl.stop();
  endtask : rd_w
  // ----------
  // Scenarios
  // ----------
  task automatic t_addr();
    for (int k = 0; k < 16; k++) begin
      pin_hi = k[3:2];
      pin_lo = k[1:0];
      repeat (4) @(negedge mclk);
      xfer_w(8'(k), 0, 16'h0);
      u_ctrl.stop();
      chk_v(25'(rd_ptr), 25'(k));
      chk_b(sda_oe, 1'b0);
      chk_b(sda_o, 1'b0);
      u_ctrl.start();
      u_ctrl.wbyte({ADDR_PREFIX, ~k[3:0], 1'b0}, a);
      chk_b(a, 1'b0);
      u_ctrl.stop();
    end
    $display("t_addr done");
  endtask : t_addr
  task automatic t_write();
    int c0;
    c0 = wr_cnt;
    xfer_w(8'h5a, 2, 16'ha53c);
    u_ctrl.stop();
    chk_v(25'(wr_cnt - c0), 25'h1);
    chk_v(wr_last, {1'b1, 8'h5a, 16'ha53c});
    // Abort after the high byte by a repeated start
    xfer_w(8'h33, 1, 16'h7100);
    xfer_w(8'h33, 0, 16'h0);
    u_ctrl.stop();
    chk_v(25'(wr_cnt - c0), 25'h1);
    chk_v(25'(rd_ptr), 25'h33);
    $display("t_write done");
  endtask : t_write
  task automatic t_read();
    rd_w(v);
    chk_v(25'(v), 25'h33cc);
    rd_w(v);
    chk_v(25'(v), 25'h33cc);
    $display("t_read done");
  endtask : t_read
  task automatic t_hs();
    u_ctrl.start();
    u_ctrl.wbyte(8'h0d, a);
    chk_b(a, 1'b0);
    chk_b(hs_mode, 1'b1);
    xfer_w(8'h44, 0, 16'h0);
    chk_b(hs_mode, 1'b1);
    u_ctrl.stop();
    repeat (10) @(negedge mclk);
    chk_b(hs_mode, 1'b0);
    $display("t_hs done");
  endtask : t_hs
  task automatic t_alert();
    cond = 1'b1;
    repeat (4) @(negedge mclk);
    chk_b(alert_oe, 1'b1);
    chk_b(alert_o, 1'b0);
    u_ctrl.start();
    u_ctrl.wbyte({ARA_ADDR, 1'b1}, a);
    chk_b(a, 1'b1);
    // A second target holds the data line low and wins
    rival = 1'b1;
    u_ctrl.rbyte(1'b0, d);
    rival = 1'b0;
    u_ctrl.stop();
    chk_b(alert_oe, 1'b1);
    u_ctrl.start();
    u_ctrl.wbyte({ARA_ADDR, 1'b1}, a);
    chk_b(a, 1'b1);
    u_ctrl.rbyte(1'b0, d);
    u_ctrl.stop();
    chk_v(25'(d), 25'({own, 1'b0}));
    chk_b(alert_oe, 1'b0);
    u_ctrl.start();
    u_ctrl.wbyte({ARA_ADDR, 1'b1}, a);
    u_ctrl.stop();
    chk_b(a, 1'b0);
    cond = 1'b0;
    hold = 1'b1;
    repeat (2) @(negedge mclk);
    cond = 1'b1;
    repeat (2) @(negedge mclk);
    cond = 1'b0;
    repeat (4) @(negedge mclk);
    chk_b(alert_oe, 1'b1);
    xfer_w(DIAG_PTR, 0, 16'h0);
    u_ctrl.stop();
    chk_b(alert_oe, 1'b1);
    rd_w(v);
    chk_b(alert_oe, 1'b0);
    pol = 1'b1;
    repeat (4) @(negedge mclk);
    chk_b(alert_oe, 1'b1);
    $display("t_alert done");
  endtask : t_alert
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    repeat (8) @(negedge mclk);
    t_addr();
    t_write();
    t_read();
    t_hs();
    t_alert();
    finish_test();
  end
  // Whole run needs about 13000 cycles
  initial begin
    repeat (60000) @(posedge mclk);
    fail_count++;
    finish_test();
  end
endmodule : its_target_tb
